// ### cso_pkg.sv
// package: register map, field layout, reset values and option codes for the call stack
package cso_pkg;

  // ****************************************************************
  // widths and depth
  // ****************************************************************
  localparam int          ADDR_W        = 8;      // register address width
  localparam int          DATA_W        = 8;      // register data width
  localparam int          PC_W          = 13;     // return address width
  localparam int          PC_HI_W       = 5;      // high part of an entry
  localparam int          PTR_W         = 3;      // stack pointer width
  localparam int          DEPTH         = 8;      // stack levels

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [7:0]  PROGRAM_FLAGS_ADDR = 8'h86;  // flag register
  localparam logic [7:0]  STACK_PTR_ADDR     = 8'hef;  // pointer register
  localparam logic [7:0]  STACK_BUF_BASE     = 8'hf0;  // first buffer byte
  localparam logic [7:0]  STACK_BUF_LAST     = 8'hff;  // last buffer byte

  // ****************************************************************
  // field positions and reset values
  // ****************************************************************
  localparam int          OVF_BIT       = 4;      // overflow flag position
  localparam logic [2:0]  PTR_RESET     = 3'h7;   // empty-stack pointer
  localparam logic [2:0]  PTR_OVF       = 3'h6;   // pointer after overflow push
  localparam logic [3:0]  DEPTH_MAX     = 4'h8;   // full depth
  localparam logic [3:0]  DEPTH_ZERO    = 4'h0;   // empty depth
  localparam logic [3:0]  DEPTH_ONE     = 4'h1;   // depth step
  localparam logic [2:0]  PTR_ONE       = 3'h1;   // pointer step

  // ****************************************************************
  // static code options
  // ****************************************************************
  typedef enum logic [2:0] {
    CSO_OSC_IHRC      = 3'h0,  // internal rc, both pins gpio
    CSO_OSC_IHRC_RTC  = 3'h1,  // internal rc plus 32768 hz crystal
    CSO_OSC_EXT_RC    = 3'h2,  // external rc, output pin gpio
    CSO_OSC_X32K      = 3'h3,  // low frequency crystal
    CSO_OSC_X12M      = 3'h4,  // 12 mhz crystal
    CSO_OSC_X4M       = 3'h5   // 4 mhz crystal
  } cso_osc_t;

  typedef enum logic [1:0] {
    CSO_DIV_1 = 2'h0,
    CSO_DIV_2 = 2'h1,
    CSO_DIV_4 = 2'h2,
    CSO_DIV_8 = 2'h3
  } cso_div_t;

endpackage : cso_pkg

// ### cso_cycle_div.sv
// instruction cycle divider producing a one-cycle enable
`timescale 1ns/1ps
module cso_cycle_div (
  input  wire logic                ref_clk,  // core clock
  input  wire logic                rst,      // sync reset
  input  wire cso_pkg::cso_div_t   div_sel,  // static divide option
  output logic                     cyc_en    // one pulse per instruction cycle
);

  logic [2:0] cnt_reg;
  logic [2:0] cnt_next;
  logic [2:0] limit;
  logic       en_next;

  // terminal count from the option, a power of two minus one
  always_comb begin
    unique case (div_sel)
      cso_pkg::CSO_DIV_1: limit = 3'h0;
      cso_pkg::CSO_DIV_2: limit = 3'h1;
      cso_pkg::CSO_DIV_4: limit = 3'h3;
      cso_pkg::CSO_DIV_8: limit = 3'h7;
    endcase
    en_next  = (cnt_reg >= limit);
    cnt_next = en_next ? 3'h0 : cnt_reg + 3'h1;
  end

  // registered so the enable leaves a flip-flop
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt_reg <= 3'h0;
      cyc_en  <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      cyc_en  <= en_next;
    end
  end

endmodule : cso_cycle_div

// ### cso_osc_pins.sv
// oscillator pin routing for the static clock source option
`timescale 1ns/1ps
module cso_osc_pins (
  input  wire logic               ref_clk,      // core clock
  input  wire logic               rst,          // sync reset
  input  wire cso_pkg::cso_osc_t  osc_sel,      // static source option
  input  wire logic               in_gpio_out,  // gpio data for input pin
  input  wire logic               in_gpio_drv,  // gpio drive request, input pin
  input  wire logic               out_gpio_out, // gpio data for output pin
  input  wire logic               out_gpio_drv, // gpio drive request, output pin
  output logic                    in_pin_o,     // input pin data
  output logic                    in_pin_oe_n,  // input pin enable, low drives
  output logic                    out_pin_o,    // output pin data
  output logic                    out_pin_oe_n, // output pin enable, low drives
  output logic                    in_is_gpio,   // input pin works as gpio
  output logic                    out_is_gpio   // output pin works as gpio
);

  logic in_gpio_next;
  logic out_gpio_next;

  // only internal rc frees both pins; external rc frees the output pin
  always_comb begin
    in_gpio_next  = (osc_sel == cso_pkg::CSO_OSC_IHRC);
    out_gpio_next = (osc_sel == cso_pkg::CSO_OSC_IHRC) ||
                    (osc_sel == cso_pkg::CSO_OSC_EXT_RC);
  end

  // oscillator pins are driven only as gpio with a drive request; otherwise the analog cell owns them
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      in_is_gpio   <= 1'b0;
      out_is_gpio  <= 1'b0;
      in_pin_o     <= 1'b0;
      out_pin_o    <= 1'b0;
      in_pin_oe_n  <= 1'b1;
      out_pin_oe_n <= 1'b1;
    end else begin
      in_is_gpio   <= in_gpio_next;
      out_is_gpio  <= out_gpio_next;
      in_pin_o     <= in_gpio_out;
      out_pin_o    <= out_gpio_out;
      in_pin_oe_n  <= ~(in_gpio_next & in_gpio_drv);
      out_pin_oe_n <= ~(out_gpio_next & out_gpio_drv);
    end
  end

endmodule : cso_osc_pins

// ### cso_call_stack.sv
// eight-level return address stack with sticky overflow flag and code options
`timescale 1ns/1ps
module cso_call_stack (
  input  wire logic                        ref_clk,        // core clock
  input  wire logic                        rst,            // system reset, sync
  input  wire cso_pkg::cso_osc_t           osc_sel,        // static source option
  input  wire cso_pkg::cso_div_t           div_sel,        // static cycle option
  input  wire logic                        opt_noise_filt, // static noise filter option
  input  wire logic [1:0]                  opt_watchdog,   // static watchdog option
  input  wire logic [1:0]                  opt_lvd,        // static lvd option
  input  wire logic                        opt_reset_pin,  // static reset pin option
  input  wire logic                        opt_security,   // static rom security option
  input  wire logic                        push_call,      // call executes
  input  wire logic                        push_irq,       // interrupt entry
  input  wire logic                        return_from_call,      // call return
  input  wire logic                        return_from_interrupt, // interrupt return
  input  wire logic [cso_pkg::PC_W-1:0]    pc_in,          // pc to save
  input  wire logic                        reg_wr,         // register write strobe
  input  wire logic                        reg_rd,         // register read strobe
  input  wire logic [cso_pkg::ADDR_W-1:0]  reg_addr,       // register address
  input  wire logic [cso_pkg::DATA_W-1:0]  reg_wdata,      // register write data
  input  wire logic                        in_gpio_out,    // gpio data, input pin
  input  wire logic                        in_gpio_drv,    // gpio drive, input pin
  input  wire logic                        out_gpio_out,   // gpio data, output pin
  input  wire logic                        out_gpio_drv,   // gpio drive, output pin
  output logic [cso_pkg::PC_W-1:0]         pc_out,         // restored pc
  output logic                             pc_load,        // pulse: load pc_out
  output logic [cso_pkg::DATA_W-1:0]       reg_rdata,      // register read data
  output logic                             reg_rvalid,     // pulse: read data valid
  output logic                             stack_overflow_flag, // sticky overflow
  output logic [cso_pkg::PTR_W-1:0]        stack_pointer,  // pointer view
  output logic                             cyc_en,         // instruction cycle enable
  output logic                             in_pin_o,       // input pin data
  output logic                             in_pin_oe_n,    // input pin enable, low drives
  output logic                             out_pin_o,      // output pin data
  output logic                             out_pin_oe_n,   // output pin enable, low drives
  output logic                             in_is_gpio,     // input pin is gpio
  output logic                             out_is_gpio,    // output pin is gpio
  output logic [6:0]                       opt_status      // latched static options
);

  // ****************************************************************
  // state
  // ****************************************************************
  localparam int D = cso_pkg::DEPTH;
  localparam int H = cso_pkg::PC_HI_W;
  localparam int L = cso_pkg::PC_W - cso_pkg::PC_HI_W;

  logic [H-1:0]                 stack_entry_high [D];
  logic [L-1:0]                 stack_entry_low  [D];
  logic [H-1:0]                 high_next        [D];
  logic [L-1:0]                 low_next         [D];
  logic [cso_pkg::PTR_W-1:0]    stack_pointer_reg;
  logic [cso_pkg::PTR_W-1:0]    ptr_next;
  logic [3:0]                   depth_reg;
  logic [3:0]                   depth_next;
  logic                         ovf_reg;
  logic                         ovf_next;
  logic [cso_pkg::PC_W-1:0]     pc_out_next;
  logic                         pc_load_next;
  logic [cso_pkg::DATA_W-1:0]   rdata_next;
  logic                         push;
  logic                         pop;
  logic [cso_pkg::PTR_W-1:0]    wr_idx;
  logic [cso_pkg::PTR_W-1:0]    rd_idx;
  logic [cso_pkg::PTR_W-1:0]    rd_ptr;
  logic [2:0]                   buf_idx;
  logic                         buf_hi;
  logic                         buf_hit;

  // ****************************************************************
  // option blocks
  // ****************************************************************
  cso_cycle_div u_div (
    .ref_clk (ref_clk),
    .rst     (rst),
    .div_sel (div_sel),
    .cyc_en  (cyc_en)
  );

  cso_osc_pins u_osc (
    .ref_clk      (ref_clk),
    .rst          (rst),
    .osc_sel      (osc_sel),
    .in_gpio_out  (in_gpio_out),
    .in_gpio_drv  (in_gpio_drv),
    .out_gpio_out (out_gpio_out),
    .out_gpio_drv (out_gpio_drv),
    .in_pin_o     (in_pin_o),
    .in_pin_oe_n  (in_pin_oe_n),
    .out_pin_o    (out_pin_o),
    .out_pin_oe_n (out_pin_oe_n),
    .in_is_gpio   (in_is_gpio),
    .out_is_gpio  (out_is_gpio)
  );

  // ****************************************************************
  // stack next-state logic
  // ****************************************************************
  // buffer bytes: low byte at even address, high byte at odd, entry = addr[3:1]
  always_comb begin
    push    = push_call | push_irq;
    pop     = return_from_call | return_from_interrupt;
    // entry index is the pointer's complement, so entry 0 fills first
    wr_idx  = ~stack_pointer_reg;
    rd_ptr  = stack_pointer_reg + cso_pkg::PTR_ONE;
    rd_idx  = ~rd_ptr;
    buf_hit = (reg_addr >= cso_pkg::STACK_BUF_BASE);
    buf_idx = reg_addr[3:1];
    buf_hi  = reg_addr[0];
  end

  // a push wins over a pop in the same cycle; the core never issues both
  always_comb begin
    ptr_next     = stack_pointer_reg;
    depth_next   = depth_reg;
    ovf_next     = ovf_reg;
    pc_out_next  = pc_out;
    pc_load_next = 1'b0;
    for (int i = 0; i < D; i++) begin
      high_next[i] = stack_entry_high[i];
      low_next[i]  = stack_entry_low[i];
    end
    // software access to pointer and buffer; the flag has no write path
    if (reg_wr && (reg_addr == cso_pkg::STACK_PTR_ADDR)) begin
      ptr_next = reg_wdata[cso_pkg::PTR_W-1:0];
    end
    if (reg_wr && buf_hit) begin
      if (buf_hi) begin
        high_next[buf_idx] = reg_wdata[H-1:0];
      end else begin
        low_next[buf_idx] = reg_wdata[L-1:0];
      end
    end
    // pointer always steps, so an overflow push from 111 lands on 110
    if (push) begin
      ptr_next = stack_pointer_reg - cso_pkg::PTR_ONE;
      if (depth_reg == cso_pkg::DEPTH_MAX) begin
        ovf_next = 1'b1;
      end else begin
        // a full stack keeps its live entries; the extra address is lost
        high_next[wr_idx] = pc_in[cso_pkg::PC_W-1:L];
        low_next[wr_idx]  = pc_in[L-1:0];
        depth_next        = depth_reg + cso_pkg::DEPTH_ONE;
      end
    end else if (pop) begin
      ptr_next     = rd_ptr;
      pc_out_next  = {stack_entry_high[rd_idx], stack_entry_low[rd_idx]};
      pc_load_next = 1'b1;
      if (depth_reg != cso_pkg::DEPTH_ZERO) begin
        depth_next = depth_reg - cso_pkg::DEPTH_ONE;
      end
    end
  end

  // only system reset clears the flag; no other term lowers it
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stack_pointer_reg <= cso_pkg::PTR_RESET;
      depth_reg         <= cso_pkg::DEPTH_ZERO;
      ovf_reg           <= 1'b0;
      pc_out            <= '0;
      pc_load           <= 1'b0;
      for (int i = 0; i < D; i++) begin
        stack_entry_high[i] <= '0;
        stack_entry_low[i]  <= '0;
      end
    end else begin
      stack_pointer_reg <= ptr_next;
      depth_reg         <= depth_next;
      ovf_reg           <= ovf_next;
      pc_out            <= pc_out_next;
      pc_load           <= pc_load_next;
      for (int i = 0; i < D; i++) begin
        stack_entry_high[i] <= high_next[i];
        stack_entry_low[i]  <= low_next[i];
      end
    end
  end

  // ****************************************************************
  // register read path
  // ****************************************************************
  // unmapped addresses read zero; other flag bits belong to other blocks
  always_comb begin
    rdata_next = '0;
    if (reg_addr == cso_pkg::PROGRAM_FLAGS_ADDR) begin
      rdata_next[cso_pkg::OVF_BIT] = ovf_reg;
    end else if (reg_addr == cso_pkg::STACK_PTR_ADDR) begin
      rdata_next[cso_pkg::PTR_W-1:0] = stack_pointer_reg;
    end else if (buf_hit) begin
      if (buf_hi) begin
        rdata_next[H-1:0] = stack_entry_high[buf_idx];
      end else begin
        rdata_next[L-1:0] = stack_entry_low[buf_idx];
      end
    end
  end

  // outputs are registered copies so they leave flip-flops
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      reg_rdata           <= '0;
      reg_rvalid          <= 1'b0;
      stack_overflow_flag <= 1'b0;
      stack_pointer       <= cso_pkg::PTR_RESET;
      opt_status          <= '0;
    end else begin
      reg_rdata           <= reg_rd ? rdata_next : reg_rdata;
      reg_rvalid          <= reg_rd;
      stack_overflow_flag <= ovf_next;
      stack_pointer       <= ptr_next;
      opt_status          <= {opt_security, opt_reset_pin, opt_lvd,
                              opt_watchdog, opt_noise_filt};
    end
  end

endmodule : cso_call_stack

// ### cso_call_stack_monitor.sv
// checker: pointer, overflow flag, pop and register read timing of the call stack
`timescale 1ns/1ps
// ****************************************************************
// checker
// ****************************************************************
module cso_call_stack_monitor (
  input wire logic       ref_clk,               // clock
  input wire logic       rst,                   // sync reset
  input wire logic       push_call,             // call
  input wire logic       push_irq,              // irq entry
  input wire logic       return_from_call,      // ret
  input wire logic       return_from_interrupt, // return_from_interrupt
  input wire logic       reg_rd,                // read strobe
  input wire logic [7:0] reg_addr,              // address
  input wire logic [7:0] reg_rdata,             // read data
  input wire logic       reg_rvalid,            // read valid
  input wire logic       pc_load,               // pc load pulse
  input wire logic       stack_overflow_flag,   // sticky flag
  input wire logic [2:0] stack_pointer          // pointer
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // a push wins over a pop in the same cycle
  wire push = push_call | push_irq;
  wire pop  = (return_from_call | return_from_interrupt) & ~push;
  a_push_ptr_dec:
    assert property (push |=> stack_pointer == $past(stack_pointer) - 3'h1)
    else $error("pointer did not step down on push");
  a_pop_ptr_inc:
    assert property (pop |=> stack_pointer == $past(stack_pointer) + 3'h1)
    else $error("pointer did not step up on pop");
  a_pop_loads_pc:
    assert property (pop |=> pc_load) else $error("pop gave no pc load");
  a_load_has_cause:
    assert property (pc_load |-> $past(pop)) else $error("pc load without pop");
  a_flag_sticky:
    assert property (stack_overflow_flag |=> stack_overflow_flag)
    else $error("overflow flag cleared without reset");
  a_flag_needs_push:
    assert property (!stack_overflow_flag && !push |=> !stack_overflow_flag)
    else $error("overflow flag set without push");
  a_read_valid:
    assert property (reg_rd |=> reg_rvalid) else $error("read gave no valid");
  a_read_flag_bit:
    assert property (reg_rd && reg_addr == cso_pkg::PROGRAM_FLAGS_ADDR |=>
      reg_rdata == {3'h0, $past(stack_overflow_flag), 4'h0})
    else $error("flag register read wrong");
  // main scenarios
  cover property ($rose(stack_overflow_flag));
  cover property (pop ##2 push);
  cover property (reg_rd && reg_addr == 8'h86 && stack_overflow_flag);
endmodule : cso_call_stack_monitor

bind cso_call_stack cso_call_stack_monitor u_mon (.ref_clk, .rst, .push_call, .push_irq,
  .return_from_call, .return_from_interrupt, .reg_rd, .reg_addr, .reg_rdata, .reg_rvalid,
  .pc_load, .stack_overflow_flag, .stack_pointer);

// ### cso_core_seq.sv
// partner: core sequencer issuing call, irq entry and return strobes
`timescale 1ns/1ps
// ****************************************************************
// sequencer
// ****************************************************************
module cso_core_seq (
  input  wire logic   ref_clk,               // clock
  output logic        push_call,             // call
  output logic        push_irq,              // irq entry
  output logic        return_from_call,      // ret
  output logic        return_from_interrupt, // return_from_interrupt
  output logic [12:0] pc_in                  // pc to save
);
  initial begin
    {push_call, push_irq, return_from_call, return_from_interrupt} = 4'h0;
    pc_in = 13'h0;
  end
  // one strobe held for one cycle from a falling edge; pc is inverted after, so no stale value lingers
  task automatic issue(input int kind, input logic [12:0] pc, input int gap);
    @(negedge ref_clk);
    push_call             = (kind == 0);
    push_irq              = (kind == 1);
    return_from_call      = (kind == 2);
    return_from_interrupt = (kind == 3);
    pc_in                 = pc;
    @(negedge ref_clk);
    {push_call, push_irq, return_from_call, return_from_interrupt} = 4'h0;
    pc_in = ~pc;
    repeat (gap) @(negedge ref_clk);
  endtask : issue
endmodule : cso_core_seq

// ### cso_call_stack_tb.sv
// testbench: call stack against a queue model, registers, options
`timescale 1ns/1ps
module cso_call_stack_tb;
  logic              ref_clk, rst, reg_wr, reg_rd, seed;
  logic              in_gpio_out, in_gpio_drv, out_gpio_out, out_gpio_drv;
  logic [7:0]        reg_addr, reg_wdata, v;
  logic [6:0]        opts;
  cso_pkg::cso_osc_t osc_sel;
  cso_pkg::cso_div_t div_sel;
  wire               push_call, push_irq, return_from_call, return_from_interrupt;
  wire  [12:0]       pc_in, pc_out;
  wire  [7:0]        reg_rdata;
  wire  [2:0]        stack_pointer;
  wire  [6:0]        opt_status;
  wire               pc_load, reg_rvalid, stack_overflow_flag, cyc_en, in_pin_o;
  wire               in_pin_oe_n, out_pin_o, out_pin_oe_n, in_is_gpio, out_is_gpio;
  int                bad_count, checked, ptr, n;
  logic              flag, g;
  logic [12:0]       q[$];

  cso_core_seq u_core (.ref_clk, .push_call, .push_irq, .return_from_call,
    .return_from_interrupt, .pc_in);
  cso_call_stack u_dut (.ref_clk, .rst, .osc_sel, .div_sel, .opt_noise_filt(opts[0]),
    .opt_watchdog(opts[2:1]), .opt_lvd(opts[4:3]), .opt_reset_pin(opts[5]),
    .opt_security(opts[6]), .push_call, .push_irq, .return_from_call,
    .return_from_interrupt, .pc_in, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .in_gpio_out,
    .in_gpio_drv, .out_gpio_out, .out_gpio_drv, .pc_out, .pc_load, .reg_rdata, .reg_rvalid,
    .stack_overflow_flag, .stack_pointer, .cyc_en, .in_pin_o, .in_pin_oe_n, .out_pin_o,
    .out_pin_oe_n, .in_is_gpio, .out_is_gpio, .opt_status);

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("checked=%0d bad_count=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish
  // register access: strobe for one cycle, address inverted once released
  task automatic reg_acc(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    {reg_wr, reg_rd, reg_addr, reg_wdata} = {wr, !wr, a, d};
    @(negedge ref_clk);
    {reg_wr, reg_rd, reg_addr} = {2'h0, ~a};
    v = reg_rdata;
  endtask : reg_acc
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    reg_acc(1'b0, a, 8'h00);
    check(16'(v), 16'(e));
    check(16'(reg_rvalid), 16'h1);
  endtask : rd_chk
  task automatic do_reset();
    @(negedge ref_clk);
    rst = 1'b1;
    repeat (5) @(negedge ref_clk);
    rst = 1'b0;
    ptr = 7;
    flag = 1'b0;
    q.delete();
  endtask : do_reset
  // model: queue holds live entries; a ninth push raises the flag and steps the pointer but stores nothing
  task automatic push_op(input int kind);
    logic [12:0] pc;
    pc = 13'($urandom);
    u_core.issue(kind, pc, $urandom % 3);
    if (q.size() == 8) flag = 1'b1;
    else q.push_back(pc);
    ptr = (ptr + 7) % 8;
    check(16'(stack_pointer), 16'(ptr));
    check(16'(stack_overflow_flag), 16'(flag));
  endtask : push_op
  task automatic pop_op(input int kind);
    u_core.issue(kind, 13'($urandom), 0);
    ptr = (ptr + 1) % 8;
    check(16'(pc_load), 16'h1);
    if (!flag) check(16'(pc_out), 16'(q.pop_back()));
    check(16'(stack_pointer), 16'(ptr));
    check(16'(stack_overflow_flag), 16'(flag));
  endtask : pop_op

  // ****************************************************************
  // clock, watchdog, sequence
  // ****************************************************************
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (5000) @(posedge ref_clk);
    bad_count++;
    tally_and_finish();
  end
  initial begin
    seed = 1'($urandom(32'h6b5e));
    {rst, reg_wr, reg_rd, reg_addr, reg_wdata} = {1'b1, 18'h0};
    {in_gpio_out, in_gpio_drv, out_gpio_out, out_gpio_drv} = 4'h0;
    osc_sel = cso_pkg::CSO_OSC_IHRC;
    div_sel = cso_pkg::CSO_DIV_1;
    opts = 7'($urandom);
    do_reset();
    rd_chk(8'h86, 8'h00);
    rd_chk(8'hef, 8'h07);
    for (int k = 0; k < 16; k++) rd_chk(8'hf0 + 8'(k), 8'h00);
    check(16'(opt_status), 16'(opts));
    // full depth, then unwind with both return kinds
    for (int k = 0; k < 8; k++) push_op(k % 2);
    for (int k = 0; k < 8; k++) begin
      rd_chk(8'hf0 + 8'(2 * k), q[k][7:0]);
      rd_chk(8'hf1 + 8'(2 * k), {3'h0, q[k][12:8]});
    end
    rd_chk(8'h86, 8'h00);
    for (int k = 0; k < 8; k++) pop_op(2 + k % 2);
    reg_acc(1'b1, 8'hef, 8'hfb);
    rd_chk(8'hef, 8'h03);
    reg_acc(1'b1, 8'hef, 8'h07);
    // overflow, write attempt on the flag, movement after it
    for (int k = 0; k < 10; k++) push_op(k % 2);
    reg_acc(1'b1, 8'h86, 8'h00);
    rd_chk(8'h86, 8'h10);
    for (int k = 0; k < 3; k++) pop_op(2 + k % 2);
    push_op(1);
    // software polls the flag and recovers by reset
    reg_acc(1'b0, 8'h86, 8'h00);
    check(16'(v[4]), 16'h1);
    if (v[4] === 1'b1) do_reset();
    rd_chk(8'h86, 8'h00);
    for (int d = 0; d < 4; d++) begin
      div_sel = cso_pkg::cso_div_t'(d);
      do_reset();
      n = 0;
      while (cyc_en !== 1'b1 && n < 40) begin
        @(negedge ref_clk);
        n++;
      end
      n = 0;
      do begin
        @(negedge ref_clk);
        n++;
      end while (cyc_en !== 1'b1 && n < 40);
      check(16'(n), 16'(1 << d));
    end
    for (int s = 0; s < 6; s++) begin
      osc_sel = cso_pkg::cso_osc_t'(s);
      {in_gpio_drv, out_gpio_drv, out_gpio_out, in_gpio_out} = 4'($urandom);
      repeat (3) @(negedge ref_clk);
      g = (s == 0) || (s == 2);
      check(16'(in_is_gpio), 16'(s == 0));
      check(16'(out_is_gpio), 16'(g));
      check(16'(out_pin_oe_n), 16'(!(g && out_gpio_drv)));
      check(16'(in_pin_oe_n), 16'(!((s == 0) && in_gpio_drv)));
      check(16'(in_pin_o), 16'(in_gpio_out));
      check(16'(out_pin_o), 16'(out_gpio_out));
    end
    tally_and_finish();
  end
endmodule : cso_call_stack_tb
